// ==== verilog/bcd_request_output_consts.svh ====
`ifndef BCD_REQUEST_OUTPUT_CONSTS_SVH
`define BCD_REQUEST_OUTPUT_CONSTS_SVH
// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_TIMING      8'h04
`define OFS_STATUS      8'h08
// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTRL_MODE_LSB   0
`define CTRL_TWO_AXIS   2
`define CTRL_IN_24V     3
`define CTRL_AUX_LATCH  4
`define CTRL_POL_DIGIT  5
`define CTRL_POL_SIGN   6
`define CTRL_POL_READY  7
`define CTRL_PWR_OFF    8
`define CTRL_ALM_OFF    9
`define CTRL_RESET      32'h0000_0080
// ----------------------------------------------------------------
// timing register fields: interval in ms, three quantity selectors
// ----------------------------------------------------------------
`define TIM_INV_LSB     0
`define TIM_SEL1_LSB    8
`define TIM_SEL2_LSB    12
`define TIM_SEL3_LSB    16
`define TIMING_RESET    32'h0002_1000
// ----------------------------------------------------------------
// timing figures
// ----------------------------------------------------------------
`define CLK_MHZ         100
`define READY_INV_US    50
`define FILTER_5V_MS    3
`define FILTER_24V_US   350
`define BASE_DELAY_MS   3
`define AXIS1_STEP_MS   8
`define AXIS2_STEP_MS   13
`define AUX_AXIS1_MS    35
`define AUX_AXIS2_MS    38
`define INV_MAX_MS      20
`endif

// ==== verilog/bcd_request_output_pkg.sv ====
package bcd_request_output_pkg;
  // output mode selected by software
  typedef enum logic [1:0] {
    MODE_CONSTANT  = 2'b00,
    MODE_LATCH     = 2'b01,
    MODE_TRISTATE  = 2'b10,
    MODE_HIGHSPEED = 2'b11
  } mode_t;
  // sequencer states
  typedef enum logic [2:0] {
    ST_RUN     = 3'b000,
    ST_REFRESH = 3'b001,
    ST_FILTER  = 3'b010,
    ST_WAIT    = 3'b011,
    ST_HOLD    = 3'b100
  } state_t;
endpackage

// ==== verilog/bcd_request_output.sv ====
`timescale 1ns/10ps
`include "bcd_request_output_consts.svh"
// Function
// - latch idle: lengthened ready gap, constant behaviour
// - one axis delay: 3, 8, 16, 24 ms
// - two axis delay: 3, 13, 26 ms
// - three-state: all outputs off without request
// - three-state: fresh data driven while requested
// - request modes share latch mode delay
// - latched aux input acts as line one
// - high-speed drives displayed value, no recompute
// - input filter 3 ms or 350 us added
// - seven digits, sign and ready in parallel
// - polarity per digit, sign and ready group
// - power-up display: data or all off
// - alarm: hold previous data or all off
// - each line selects one of six quantities
// - ready low while data is refreshed
// - ready gap set in whole milliseconds
module bcd_request_output
  import bcd_request_output_pkg::*;
#(
  parameter int unsigned CYC_PER_MS  = `CLK_MHZ * 1000,
  parameter int unsigned CYC_RDY_INV = `READY_INV_US * `CLK_MHZ,
  parameter int unsigned CYC_F24     = `FILTER_24V_US * `CLK_MHZ,
  parameter int unsigned DIGITS      = 7
) (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 hsel,
  input  wire logic [7:0]           haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  input  wire logic                 data_request_one,
  input  wire logic                 data_request_two,
  input  wire logic                 data_request_three,
  input  wire logic                 aux_universal_input,
  input  wire logic [6*DIGITS*4-1:0] quantity_bcd,
  input  wire logic [5:0]           quantity_sign,
  input  wire logic                 powerup_active,
  input  wire logic                 alarm_active,
  output logic [DIGITS*4-1:0]       bcd_out,
  output logic                      sign_out,
  output logic                      ready_out,
  output logic                      output_enable
);
  localparam int unsigned W = DIGITS * 4;

  if (DIGITS < 1 || CYC_PER_MS < 1 || CYC_RDY_INV < 1 || CYC_F24 < 1) begin : g_chk
    $error("bcd_request_output: parameters out of range");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // snapped refresh period in ms for a set interval; odd border values
  // (9, 17 on one axis, 14 on two) take the lower neighbour
  function automatic logic [5:0] snap_ms(input logic [4:0] set, input logic two);
    logic [5:0] r;
    r = 6'(`BASE_DELAY_MS);
    if (set != 5'h00) begin
      if (two)
        r = (set <= 5'd14) ? 6'(`AXIS2_STEP_MS) : 6'(2 * `AXIS2_STEP_MS);
      else if (set <= 5'd9)
        r = 6'(`AXIS1_STEP_MS);
      else if (set <= 5'd17)
        r = 6'(2 * `AXIS1_STEP_MS);
      else
        r = 6'(3 * `AXIS1_STEP_MS);
    end
    return r;
  endfunction

  // pick one of six quantities, sign on top
  function automatic logic [W:0] pick(input logic [2:0] s, input logic [6*W-1:0] q,
                                     input logic [5:0] sg);
    logic [2:0] k;
    k = (s > 3'd5) ? 3'd0 : s;
    return {sg[k], q[k*W +: W]};
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync1_q;  // first stage, read only by second
  logic [3:0] sync2_q;  // stable request levels

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {aux_universal_input, data_request_three, data_request_two,
                  data_request_one};
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // register file over the bus
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q, ctrl_d;      // mode, axes, polarity, off choices
  logic [31:0] tim_q, tim_d;        // ready gap and quantity selectors
  logic        wr_pend_q, wr_pend_d; // write data phase pending
  logic [7:0]  wr_addr_q, wr_addr_d;
  logic [31:0] rdata_d;
  logic [31:0] status;
  logic        addr_ok;

  assign addr_ok   = hsel && hready && htrans[1];
  assign hreadyout = 1'b1; // zero wait states
  assign hresp     = 1'b0; // always okay

  // register update and read mux
  always_comb begin
    ctrl_d    = ctrl_q;
    tim_d     = tim_q;
    wr_pend_d = addr_ok && hwrite;
    wr_addr_d = addr_ok ? haddr : wr_addr_q;
    rdata_d   = hrdata;
    if (wr_pend_q) begin
      case (wr_addr_q)
        `OFS_CTRL:   ctrl_d = {22'h0, hwdata[9:0]};
        `OFS_TIMING: begin
          // intervals beyond the limit are clamped rather than refused
          tim_d = {13'h0, hwdata[18:16], 1'b0, hwdata[14:12], 1'b0, hwdata[10:8], 3'h0,
                   (hwdata[4:0] > 5'(`INV_MAX_MS)) ? 5'(`INV_MAX_MS) : hwdata[4:0]};
        end
        default: ;  // unmapped or read-only: write ignored
      endcase
    end
    if (addr_ok && !hwrite) begin
      case (haddr)
        `OFS_CTRL:   rdata_d = ctrl_q;
        `OFS_TIMING: rdata_d = tim_q;
        `OFS_STATUS: rdata_d = status;
        default:     rdata_d = 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q    <= `CTRL_RESET;
      tim_q     <= `TIMING_RESET;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata    <= 32'h0000_0000;
    end else begin
      ctrl_q    <= ctrl_d;
      tim_q     <= tim_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      hrdata    <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // decoded configuration
  // ----------------------------------------------------------------
  mode_t      mode;
  logic       two_axis;
  logic [4:0] inv_set;
  logic [3:0] req;     // one, two, three, aux
  logic [2:0] sel;     // selector of the active line
  logic       any_req;
  logic [31:0] filt_cyc, wait_cyc, per_cyc, gap_cyc;

  assign mode     = mode_t'(ctrl_q[`CTRL_MODE_LSB +: 2]);
  assign two_axis = ctrl_q[`CTRL_TWO_AXIS];
  assign inv_set  = tim_q[`TIM_INV_LSB +: 5];
  // aux counts only when configured as latched
  assign req      = {sync2_q[3] & ctrl_q[`CTRL_AUX_LATCH], sync2_q[2:0]};
  assign any_req  = |req;
  // the host keeps one line at a time; lowest line wins otherwise
  assign sel = (req[0] | req[3]) ? tim_q[`TIM_SEL1_LSB +: 3] :
               req[1] ? tim_q[`TIM_SEL2_LSB +: 3] : tim_q[`TIM_SEL3_LSB +: 3];

  // filter delay per input voltage
  assign filt_cyc = ctrl_q[`CTRL_IN_24V] ? CYC_F24 : 32'(`FILTER_5V_MS) * CYC_PER_MS;
  // request to data delay after the filter, same for every request mode
  assign wait_cyc = req[3] ?
    32'(`BASE_DELAY_MS + (two_axis ? `AUX_AXIS2_MS : `AUX_AXIS1_MS)) * CYC_PER_MS :
    32'(snap_ms(inv_set, two_axis)) * CYC_PER_MS;
  // idle data valid time and ready gap
  assign per_cyc = 32'(two_axis ? `AXIS2_STEP_MS : `AXIS1_STEP_MS) * CYC_PER_MS;
  assign gap_cyc = (inv_set == 5'h00) ? CYC_RDY_INV :
                   32'(snap_ms(inv_set, two_axis)) * CYC_PER_MS;

  // ----------------------------------------------------------------
  // sequencer and output data
  // ----------------------------------------------------------------
  state_t      state_q, state_d;
  logic [31:0] cnt_q, cnt_d;        // cycles spent in current state; held at zero in ST_HOLD
  logic [W:0]  data_q, data_d;      // sign and digits being shown
  logic [6*W-1:0] disp_q, disp_d;   // last computed (displayed) values
  logic [5:0]  dsgn_q, dsgn_d;
  logic        rdy_q, rdy_d;        // ready, active high inside
  logic        on_q, on_d;          // outputs driven
  logic        freeze;              // alarm keeps the old data
  logic        load;

  assign freeze = alarm_active && !powerup_active && !ctrl_q[`CTRL_ALM_OFF];

  // next state, counter and data
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q + 32'h0000_0001;
    data_d  = data_q;
    disp_d  = disp_q;
    dsgn_d  = dsgn_q;
    rdy_d   = rdy_q;
    on_d    = on_q;
    load    = 1'b0;
    case (state_q)
      ST_RUN: begin
        // idle: constant modes show data, request modes keep all off
        on_d  = (mode == MODE_CONSTANT) || (mode == MODE_LATCH);
        rdy_d = on_d;
        if (any_req && mode != MODE_CONSTANT) begin
          state_d = ST_FILTER;
          cnt_d   = 32'h0000_0000;
        end else if (cnt_q + 32'h0000_0001 >= per_cyc) begin
          state_d = ST_REFRESH;
          cnt_d   = 32'h0000_0000;
          rdy_d   = 1'b0;
        end
      end
      ST_REFRESH: begin
        rdy_d = 1'b0;
        // request modes go dark at once, even in the middle of a gap
        on_d  = (mode == MODE_CONSTANT) || (mode == MODE_LATCH);
        if (any_req && mode != MODE_CONSTANT) begin
          // a long gap must not add to the request delay
          state_d = ST_FILTER;
          cnt_d   = 32'h0000_0000;
        end else if (cnt_q + 32'h0000_0001 >= gap_cyc) begin
          // new computation ends: display and constant output take it
          disp_d  = quantity_bcd;
          dsgn_d  = quantity_sign;
          load    = (mode == MODE_CONSTANT) || (mode == MODE_LATCH);
          if (load && !freeze)
            data_d = pick(tim_q[`TIM_SEL1_LSB +: 3], quantity_bcd, quantity_sign);
          rdy_d   = on_d;
          state_d = ST_RUN;
          cnt_d   = 32'h0000_0000;
        end
      end
      ST_FILTER: begin
        // old behaviour continues until the request is recognised
        if (!any_req) begin
          state_d = ST_RUN;
          cnt_d   = 32'h0000_0000;
        end else if (cnt_q + 32'h0000_0001 >= filt_cyc) begin
          state_d = ST_WAIT;
          cnt_d   = 32'h0000_0000;
          rdy_d   = 1'b0;
        end
      end
      ST_WAIT: begin
        rdy_d = 1'b0;
        if (!any_req) begin
          state_d = ST_RUN;
          cnt_d   = 32'h0000_0000;
        end else if (cnt_q + 32'h0000_0001 >= wait_cyc) begin
          if (!freeze) begin
            if (mode == MODE_HIGHSPEED)
              data_d = pick(sel, disp_q, dsgn_q);
            else
              data_d = pick(sel, quantity_bcd, quantity_sign);
          end
          if (mode != MODE_HIGHSPEED) begin
            disp_d = quantity_bcd;
            dsgn_d = quantity_sign;
          end
          on_d    = 1'b1;
          rdy_d   = 1'b1;
          state_d = ST_HOLD;
          cnt_d   = 32'h0000_0000;
        end
      end
      ST_HOLD: begin
        // data stands unchanged while the request is held
        cnt_d = cnt_q;
        if (!any_req) begin
          state_d = ST_RUN;
          cnt_d   = 32'h0000_0000;
          on_d    = (mode == MODE_CONSTANT) || (mode == MODE_LATCH);
          rdy_d   = on_d;
        end
      end
      default: begin
        state_d = ST_RUN;
        cnt_d   = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_RUN;
      cnt_q   <= 32'h0000_0000;
      data_q  <= '0;
      disp_q  <= '0;
      dsgn_q  <= 6'h00;
      rdy_q   <= 1'b0;
      on_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      data_q  <= data_d;
      disp_q  <= disp_d;
      dsgn_q  <= dsgn_d;
      rdy_q   <= rdy_d;
      on_q    <= on_d;
    end
  end

  // ----------------------------------------------------------------
  // pin drivers with polarity and off states
  // ----------------------------------------------------------------
  logic kill;  // power-up or alarm choice forces all off
  logic drive; // pins active next cycle
  logic [W+1:0] pin_d, pin_q; // ready, sign, digits
  logic         oe_q;

  assign kill  = (powerup_active && ctrl_q[`CTRL_PWR_OFF]) ||
                 (alarm_active && !powerup_active && ctrl_q[`CTRL_ALM_OFF]);
  assign drive = on_q && !kill;

  // polarity is applied only while driving; off means released lines
  always_comb begin
    pin_d = '0;
    if (drive)
      pin_d = {rdy_q ^ ctrl_q[`CTRL_POL_READY],
               data_q[W] ^ ctrl_q[`CTRL_POL_SIGN],
               data_q[W-1:0] ^ {W{ctrl_q[`CTRL_POL_DIGIT]}}};
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_q <= '0;
      oe_q  <= 1'b0;
    end else begin
      pin_q <= pin_d;
      oe_q  <= drive;
    end
  end

  assign bcd_out       = pin_q[W-1:0];
  assign sign_out      = pin_q[W];
  assign ready_out     = pin_q[W+1];
  assign output_enable = oe_q;
  assign status        = {20'h0, sel, 1'b0, req, oe_q, state_q};
endmodule

// ==== sim/bcd_request_output_properties.sv ====
`timescale 1ns/10ps
module bcd_request_output_properties #(
  parameter int unsigned DIGITS = 7
) (
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              hsel,
  input wire logic [7:0]        haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic              data_request_one,
  input wire logic              data_request_two,
  input wire logic              data_request_three,
  input wire logic              aux_universal_input,
  input wire logic              powerup_active,
  input wire logic              alarm_active,
  input wire logic [DIGITS*4-1:0] bcd_out,
  input wire logic              sign_out,
  input wire logic              ready_out,
  input wire logic              output_enable
);
  // ----------------------------------------------------------------
  // shadow of the control register, updated like the real one
  // ----------------------------------------------------------------
  logic       wr_q;    // control write now in data phase
  logic [9:0] ctrl_q;  // mode, polarity and off choices
  wire        mode_req = ctrl_q[1];  // three-state or high-speed
  wire        any_req = data_request_one | data_request_two |
                        data_request_three | aux_universal_input;
  // capture on the data phase edge, as the slave does
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q   <= 1'b0;
      ctrl_q <= 10'h080;
    end else begin
      wr_q <= hsel && hready && htrans[1] && hwrite && (haddr == 8'h00);
      if (wr_q) begin
        ctrl_q <= hwdata[9:0];
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  // quiet stretch: request mode with no line up for five samples
  sequence idle_s;
    (mode_req && !any_req) [*5];
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  a_off_zero: assert property (!output_enable |-> bcd_out == '0 && !sign_out && !ready_out)
    else $error("outputs active while disabled");
  a_idle_off: assert property (idle_s |=> !output_enable)
    else $error("outputs on without request");
  a_filter_first: assert property ($rose(output_enable) && mode_req |-> $past(any_req, 8))
    else $error("output before request filtered");
  a_hold_data: assert property ($past(mode_req, 4) && mode_req && output_enable
    && $past(output_enable) |-> $stable(bcd_out) && $stable(sign_out))
    else $error("held data changed");
  a_powerup_off: assert property (powerup_active && ctrl_q[8] |-> ##[1:2] !output_enable)
    else $error("outputs on during power-up display");
  a_alarm_off: assert property (alarm_active && !powerup_active && ctrl_q[9]
    |-> ##[1:2] !output_enable)
    else $error("outputs on during alarm");
  a_alarm_hold: assert property (alarm_active && $past(alarm_active, 3) && !ctrl_q[9]
    && !powerup_active && output_enable && $past(output_enable) |-> $stable(bcd_out))
    else $error("data changed during alarm");
endmodule
bind bcd_request_output bcd_request_output_properties #(.DIGITS(DIGITS)) u_props (
  .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .data_request_one(data_request_one),
  .data_request_two(data_request_two), .data_request_three(data_request_three),
  .aux_universal_input(aux_universal_input), .powerup_active(powerup_active),
  .alarm_active(alarm_active), .bcd_out(bcd_out), .sign_out(sign_out),
  .ready_out(ready_out), .output_enable(output_enable));

// ==== sim/controller_model.sv ====
`timescale 1ns/10ps
module controller_model (
  input  wire logic clk,
  input  wire logic output_enable,
  output logic      req_one,
  output logic      req_two,
  output logic      req_three,
  output logic      aux_req
);
  // ----------------------------------------------------------------
  // reading controller: one line at a time, level held until done
  // ----------------------------------------------------------------
  initial begin
    req_one   = 1'b0;
    req_two   = 1'b0;
    req_three = 1'b0;
    aux_req   = 1'b0;
  end
  // raise one line only, then count cycles until the pins are driven
  task automatic fetch(input int k, output int cyc);
    cyc = 0;
    @(posedge clk);
    case (k)
      0: req_one <= 1'b1;
      1: req_two <= 1'b1;
      2: req_three <= 1'b1;
      default: aux_req <= 1'b1;
    endcase
    while (output_enable !== 1'b1 && cyc < 2000) begin
      @(posedge clk);
      cyc++;
    end
  endtask
  // release, then keep 5 ms of quiet before any further request
  task automatic drop();
    @(posedge clk);
    {req_one, req_two, req_three, aux_req} <= 4'h0;
    repeat (50) @(posedge clk);
  endtask
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/10ps
module testbench;
  logic          clk = 1'b0;
  logic          reset_n;
  logic          hsel, hwrite, hreadyout, hresp;
  logic [7:0]    haddr;
  logic [1:0]    htrans;
  logic [2:0]    hsize;
  logic [31:0]   hwdata, hrdata, rdata;
  logic          r1, r2, r3, rx, powerup_active, alarm_active;
  logic [167:0]  quantity_bcd;
  logic [5:0]    quantity_sign;
  logic [27:0]   bcd_out, ex;
  logic          sign_out, ready_out, output_enable;
  int            failures = 0, samples_checked = 0, cycles = 0, n, e;
  // request table: line, mode, two axis, setting, delay ms, selector
  int ln[9] = '{0, 1, 2, 0, 0, 0, 0, 0, 3};
  int md[9] = '{2, 2, 3, 2, 2, 2, 2, 2, 2};
  int tw[9] = '{0, 0, 0, 0, 0, 0, 1, 1, 0};
  int ts[9] = '{0, 0, 0, 9, 10, 20, 14, 15, 0};
  int ms[9] = '{3, 3, 3, 8, 16, 24, 13, 26, 38};
  int sl[9] = '{0, 0, 0, 3, 4, 5, 1, 2, 0};
  bcd_request_output #(.CYC_PER_MS(10), .CYC_RDY_INV(5), .CYC_F24(4)) dut (
    .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .data_request_one(r1), .data_request_two(r2), .data_request_three(r3),
    .aux_universal_input(rx), .quantity_bcd(quantity_bcd),
    .quantity_sign(quantity_sign), .powerup_active(powerup_active),
    .alarm_active(alarm_active), .bcd_out(bcd_out), .sign_out(sign_out),
    .ready_out(ready_out), .output_enable(output_enable));
  controller_model partner (.clk(clk), .output_enable(output_enable),
    .req_one(r1), .req_two(r2), .req_three(r3), .aux_req(rx));
  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      stop_test();
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (failures == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_range(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      failures++;
      $display("FAIL %0t got %h exp %h", $time, got, lo);
    end
  endtask
  // one single word transfer; the master waits on hready every phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {hsel, haddr, htrans, hwrite} <= {1'b1, a, 2'h2, wr};
    do @(posedge clk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdata = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check_val(rdata, exp);
  endtask
  // let a refresh pass, then stop where ready shows valid
  task automatic settle(input logic vld);
    repeat (200) @(posedge clk);
    while (ready_out !== vld) @(posedge clk);
  endtask
  // length of one ready gap, after the new setting has taken hold
  task automatic gap(output int g);
    g = 0;
    repeat (300) @(posedge clk);
    while (ready_out === 1'b0) @(posedge clk);
    while (ready_out !== 1'b0) @(posedge clk);
    while (ready_out === 1'b0) begin
      @(posedge clk);
      g++;
    end
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize = 3'h2;
    {powerup_active, alarm_active} = 2'h0;
    quantity_sign = 6'h2a;
    for (int k = 0; k < 6; k++) quantity_bcd[k*28 +: 28] = 28'h765_4320 + 28'(k);
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rd_chk(8'h00, 32'h0000_0080);
    rd_chk(8'h04, 32'h0002_1000);
    rd_chk(8'h0c, 32'h0000_0000);
    bus(1'b1, 8'h04, 32'h0002_1019);
    rd_chk(8'h04, 32'h0002_1014);
    bus(1'b1, 8'h04, 32'h0002_1000);
    settle(1'b0);
    check_val({3'h0, bcd_out, sign_out}, {3'h0, 28'h765_4320, 1'b0});
    bus(1'b1, 8'h00, 32'h0000_0060);
    settle(1'b1);
    check_val({3'h0, bcd_out, sign_out}, {3'h0, ~28'h765_4320, 1'b1});
    bus(1'b1, 8'h00, 32'h0000_0009);
    bus(1'b1, 8'h04, 32'h0002_1005);
    gap(n);
    check_range(n, 76, 86);
    bus(1'b1, 8'h04, 32'h0002_1000);
    gap(n);
    check_range(n, 4, 7);
    bus(1'b1, 8'h00, 32'h0000_000a);
    repeat (10) @(posedge clk);
    check_val({3'h0, output_enable, bcd_out}, 32'h0000_0000);
    for (int i = 0; i < 9; i++) begin
      bus(1'b1, 8'h00, 32'(md[i] + 8 + tw[i] * 4 + (ln[i] == 3) * 16));
      bus(1'b1, 8'h04, 32'h0002_1000 + 32'(sl[i] * 256 + ts[i]));
      partner.fetch(ln[i], n);
      check_range(n, ms[i] * 10 + 4, ms[i] * 10 + 12);
      e = (ln[i] == 1) ? 1 : (ln[i] == 2) ? 2 : sl[i];
      ex = 28'h765_4320 + 28'(e);
      check_val({2'h0, ready_out, sign_out, bcd_out}, {2'h0, 1'b1, quantity_sign[e], ex});
      quantity_bcd[e*28 +: 28] <= 28'h111_1111;
      repeat (20) @(posedge clk);
      check_val({4'h0, bcd_out}, {4'h0, ex});
      quantity_bcd[e*28 +: 28] <= ex;
      partner.drop();
      check_val({3'h0, output_enable, bcd_out}, 32'h0000_0000);
    end
    bus(1'b1, 8'h00, 32'h0000_0300);
    powerup_active <= 1'b1;
    repeat (20) @(posedge clk);
    check_val({31'h0, output_enable}, 32'h0000_0000);
    {powerup_active, alarm_active} <= 2'h1;
    repeat (20) @(posedge clk);
    check_val({31'h0, output_enable}, 32'h0000_0000);
    alarm_active <= 1'b0;
    bus(1'b1, 8'h00, 32'h0000_0000);
    settle(1'b1);
    alarm_active <= 1'b1;
    quantity_bcd[27:0] <= 28'h111_1111;
    repeat (200) @(posedge clk);
    check_val({4'h0, bcd_out}, {4'h0, 28'h765_4320});
    alarm_active <= 1'b0;
    stop_test();
  end
endmodule
